/* File: tmr16_pkg.sv */
// tmr16_pkg: register map, field layout, reset values and carrier types
// for the 16-bit capture/match/pwm timer; used by tmr16_top only.
package tmr16_pkg;

  localparam logic [7:0] OFF_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFF_RUN_CTRL = 8'h04;
  localparam logic [7:0] OFF_TIMER_COUNT = 8'h08;
  localparam logic [7:0] OFF_TICK_DIV = 8'h0c;
  localparam logic [7:0] OFF_TICK_CNT = 8'h10;
  localparam logic [7:0] OFF_MATCH_ACT = 8'h14;
  localparam logic [7:0] OFF_MATCH0 = 8'h18;
  localparam logic [7:0] OFF_CAPT_CTRL = 8'h28;
  localparam logic [7:0] OFF_CAPT0 = 8'h2c;
  localparam logic [7:0] OFF_EXT_MATCH = 8'h3c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h40;
  localparam logic [7:0] OFF_SRC_CTRL = 8'h70;
  localparam logic [7:0] OFF_PWM_CTRL = 8'h74;

  localparam int NUM_CH = 4;
  localparam int IRQ_CAPT_POS = 4;
  localparam int RUN_EN_POS = 0;
  localparam int RUN_RST_POS = 1;
  localparam int ACT_IRQ_POS = 0;
  localparam int ACT_RST_POS = 1;
  localparam int ACT_STOP_POS = 2;
  localparam int CAP_RISE_POS = 0;
  localparam int CAP_FALL_POS = 1;
  localparam int CAP_IRQ_POS = 2;
  localparam int EXT_CTRL_POS = 4;
  localparam int SRC_INPUT_POS = 2;

  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    TMR16_EXT_NONE = 2'h0,
    TMR16_EXT_LOW = 2'h1,
    TMR16_EXT_HIGH = 2'h2,
    TMR16_EXT_TOGGLE = 2'h3
  } tmr16_ext_e;

  typedef enum logic [1:0] {
    TMR16_SRC_TIMER = 2'h0,
    TMR16_SRC_RISE = 2'h1,
    TMR16_SRC_FALL = 2'h2,
    TMR16_SRC_BOTH = 2'h3
  } tmr16_src_e;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } tmr16_req_s;

endpackage : tmr16_pkg

/* File: tmr16_top.sv */
// tmr16_top: 16-bit timer/counter with prescaler, four match and four
// capture channels, external match and single edge pwm outputs, apb slave.
// assumes capture inputs are asynchronous pins; apb master on pclk.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps

module tmr16_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] capture_input,
  output logic [3:0] match_output,
  output logic irq
);

  // identical instances differ only in where the bus decodes them
  // unconnected capture pins should be tied low at the pad level

  tmr16_pkg::tmr16_req_s req;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic [1:0] run_ctrl_reg;
  logic [15:0] timer_count_reg;
  logic [15:0] tick_divider_value_reg;
  logic [15:0] tick_cnt_reg;
  logic [11:0] match_action_control_reg;
  logic [15:0] match_reg [4];
  logic [11:0] capt_ctrl_reg;
  logic [15:0] capt_reg [4];
  logic [11:0] external_match_control_reg;
  logic [3:0] count_source_control_reg;
  logic [3:0] pulse_width_control_reg;
  logic [3:0] cap_s1_reg;
  logic [3:0] cap_s2_reg;
  logic [3:0] cap_d_reg;
  logic [3:0] match_hit_reg;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  wire wr_en = psel & penable & req.write;
  wire rd_en = psel & penable & ~req.write;
  assign pready = 1'b1;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  wire [3:0] cap_rise = cap_s2_reg & ~cap_d_reg;
  wire [3:0] cap_fall = ~cap_s2_reg & cap_d_reg;

  wire counting = run_ctrl_reg[tmr16_pkg::RUN_EN_POS] &
                  ~run_ctrl_reg[tmr16_pkg::RUN_RST_POS];
  wire [1:0] src_sel = count_source_control_reg[3:2];
  tmr16_pkg::tmr16_src_e src_mode;
  assign src_mode = tmr16_pkg::tmr16_src_e'(count_source_control_reg[1:0]);
  wire src_rise = cap_rise[src_sel];
  wire src_fall = cap_fall[src_sel];
  wire src_edge = (src_mode == tmr16_pkg::TMR16_SRC_RISE) ? src_rise :
                  (src_mode == tmr16_pkg::TMR16_SRC_FALL) ? src_fall :
                  (src_rise | src_fall);
  // prescaler runs on pclk in timer mode, on source edges in counter mode
  wire tick_in = (src_mode == tmr16_pkg::TMR16_SRC_TIMER) ? 1'b1 :
                 src_edge;
  wire pre_step = counting & tick_in;
  wire tick = pre_step & (tick_cnt_reg == tick_divider_value_reg);

  wire [3:0] match_eq;
  wire [3:0] act_rst;
  wire [3:0] act_stop;
  wire [3:0] act_irq;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      assign match_eq[g] = (timer_count_reg == match_reg[g]);
      assign act_irq[g] = match_action_control_reg[3*g];
      assign act_rst[g] = match_action_control_reg[3*g+1];
      assign act_stop[g] = match_action_control_reg[3*g+2];
    end
  endgenerate

  // match acts at the end of the tick in which the count equals the value,
  // so the matched count lasts a full tick before it resets
  wire [3:0] match_fire = match_eq & {4{tick}};
  wire do_reset = |(match_fire & act_rst);
  wire do_stop = |(match_fire & act_stop);
  // a stop match freezes the count at the matched value, not one past it
  wire [15:0] count_next = do_reset ? tmr16_pkg::COUNT_RST :
                           do_stop ? timer_count_reg :
                           timer_count_reg + 16'h0001;

  wire bus_irq_wr = wr_en & hit(req.addr, tmr16_pkg::OFF_IRQ_STATUS);
  wire [3:0] cap_hit;
  generate
    for (g = 0; g < 4; g++) begin : g_cap
      assign cap_hit[g] = (capt_ctrl_reg[3*g] & cap_rise[g]) |
                          (capt_ctrl_reg[3*g+1] & cap_fall[g]);
    end
  endgenerate
  wire [3:0] cap_irq_set = cap_hit & {capt_ctrl_reg[11], capt_ctrl_reg[8],
                                      capt_ctrl_reg[5], capt_ctrl_reg[2]};
  // match flag is set two clocks after the match fires, via match_hit_reg
  wire [7:0] irq_set = {cap_irq_set, match_hit_reg & act_irq};
  wire [7:0] irq_clr = bus_irq_wr ? req.wdata[7:0] : 8'h00;
  wire [7:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
  assign irq = |(irq_status_reg & irq_mask_reg);

  // external match actions; pwm channels override the action field
  logic [3:0] ext_next;
  wire cycle_start = |(match_fire & act_rst);
  always_comb begin
    ext_next = external_match_control_reg[3:0];
    for (int i = 0; i < 4; i++) begin
      if (pulse_width_control_reg[i]) begin
        if (cycle_start && match_reg[i] != 16'h0000) begin
          ext_next[i] = 1'b0;
        end
        if (match_fire[i]) begin
          ext_next[i] = 1'b1;
        end
      end else if (match_fire[i]) begin
        unique case (tmr16_pkg::tmr16_ext_e'(
                     external_match_control_reg[4+2*i +: 2]))
          tmr16_pkg::TMR16_EXT_NONE: ext_next[i] = ext_next[i];
          tmr16_pkg::TMR16_EXT_LOW: ext_next[i] = 1'b0;
          tmr16_pkg::TMR16_EXT_HIGH: ext_next[i] = 1'b1;
          tmr16_pkg::TMR16_EXT_TOGGLE: ext_next[i] = ~ext_next[i];
        endcase
      end
    end
  end
  assign match_output = external_match_control_reg[3:0];

  wire [31:0] rd_mux =
    hit(req.addr, tmr16_pkg::OFF_IRQ_STATUS) ? {24'h0, irq_status_reg} :
    hit(req.addr, tmr16_pkg::OFF_IRQ_MASK) ? {24'h0, irq_mask_reg} :
    hit(req.addr, tmr16_pkg::OFF_RUN_CTRL) ? {30'h0, run_ctrl_reg} :
    hit(req.addr, tmr16_pkg::OFF_TIMER_COUNT) ? {16'h0, timer_count_reg} :
    hit(req.addr, tmr16_pkg::OFF_TICK_DIV) ? {16'h0, tick_divider_value_reg} :
    hit(req.addr, tmr16_pkg::OFF_TICK_CNT) ? {16'h0, tick_cnt_reg} :
    hit(req.addr, tmr16_pkg::OFF_MATCH_ACT) ?
      {20'h0, match_action_control_reg} :
    hit(req.addr, tmr16_pkg::OFF_MATCH0) ? {16'h0, match_reg[0]} :
    hit(req.addr, 8'h1c) ? {16'h0, match_reg[1]} :
    hit(req.addr, 8'h20) ? {16'h0, match_reg[2]} :
    hit(req.addr, 8'h24) ? {16'h0, match_reg[3]} :
    hit(req.addr, tmr16_pkg::OFF_CAPT_CTRL) ? {20'h0, capt_ctrl_reg} :
    hit(req.addr, tmr16_pkg::OFF_CAPT0) ? {16'h0, capt_reg[0]} :
    hit(req.addr, 8'h30) ? {16'h0, capt_reg[1]} :
    hit(req.addr, 8'h34) ? {16'h0, capt_reg[2]} :
    hit(req.addr, 8'h38) ? {16'h0, capt_reg[3]} :
    hit(req.addr, tmr16_pkg::OFF_EXT_MATCH) ?
      {20'h0, external_match_control_reg} :
    hit(req.addr, tmr16_pkg::OFF_SRC_CTRL) ? {28'h0, count_source_control_reg} :
    hit(req.addr, tmr16_pkg::OFF_PWM_CTRL) ? {28'h0, pulse_width_control_reg} :
    32'h0;
  wire mapped = (req.addr[1:0] == 2'h0) &&
                ((req.addr <= 8'h40) || hit(req.addr, tmr16_pkg::OFF_SRC_CTRL) ||
                 hit(req.addr, tmr16_pkg::OFF_PWM_CTRL));
  assign pslverr = psel & penable & ~mapped;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1_reg <= 4'h0;
      cap_s2_reg <= 4'h0;
      cap_d_reg <= 4'h0;
    end else begin
      cap_s1_reg <= capture_input;
      cap_s2_reg <= cap_s1_reg;
      cap_d_reg <= cap_s2_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= tmr16_pkg::REG_RST;
      irq_status_reg <= 8'h00;
      match_hit_reg <= 4'h0;
    end else begin
      prdata <= (psel & ~penable & ~req.write) ? rd_mux : prdata;
      irq_status_reg <= irq_status_next;
      match_hit_reg <= match_fire;
    end
  end

  // count and prescaler; bus writes take priority over counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_reg <= tmr16_pkg::COUNT_RST;
      tick_cnt_reg <= tmr16_pkg::COUNT_RST;
      run_ctrl_reg <= 2'h0;
    end else begin
      if (wr_en && hit(req.addr, tmr16_pkg::OFF_RUN_CTRL)) begin
        run_ctrl_reg <= req.wdata[1:0];
      end else if (do_stop) begin
        run_ctrl_reg[tmr16_pkg::RUN_EN_POS] <= 1'b0;
      end
      if (run_ctrl_reg[tmr16_pkg::RUN_RST_POS]) begin
        timer_count_reg <= tmr16_pkg::COUNT_RST;
        tick_cnt_reg <= tmr16_pkg::COUNT_RST;
      end else if (wr_en && hit(req.addr, tmr16_pkg::OFF_TIMER_COUNT)) begin
        timer_count_reg <= req.wdata[15:0];
      end else if (wr_en && hit(req.addr, tmr16_pkg::OFF_TICK_CNT)) begin
        tick_cnt_reg <= req.wdata[15:0];
      end else if (tick) begin
        timer_count_reg <= count_next;
        tick_cnt_reg <= tmr16_pkg::COUNT_RST;
      end else if (pre_step) begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= 8'h00;
      tick_divider_value_reg <= 16'h0000;
      match_action_control_reg <= 12'h000;
      capt_ctrl_reg <= 12'h000;
      external_match_control_reg <= 12'h000;
      count_source_control_reg <= 4'h0;
      pulse_width_control_reg <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        match_reg[i] <= 16'h0000;
        capt_reg[i] <= 16'h0000;
      end
    end else begin
      if (wr_en && hit(req.addr, tmr16_pkg::OFF_IRQ_MASK))
        irq_mask_reg <= req.wdata[7:0];
      if (wr_en && hit(req.addr, tmr16_pkg::OFF_TICK_DIV))
        tick_divider_value_reg <= req.wdata[15:0];
      if (wr_en && hit(req.addr, tmr16_pkg::OFF_MATCH_ACT))
        match_action_control_reg <= req.wdata[11:0];
      if (wr_en && hit(req.addr, tmr16_pkg::OFF_CAPT_CTRL))
        capt_ctrl_reg <= req.wdata[11:0];
      if (wr_en && hit(req.addr, tmr16_pkg::OFF_EXT_MATCH))
        // software write of the output bits wins over a match that clock
        external_match_control_reg <= req.wdata[11:0];
      else
        external_match_control_reg[3:0] <= ext_next;
      if (wr_en && hit(req.addr, tmr16_pkg::OFF_SRC_CTRL))
        count_source_control_reg <= req.wdata[3:0];
      if (wr_en && hit(req.addr, tmr16_pkg::OFF_PWM_CTRL))
        pulse_width_control_reg <= req.wdata[3:0];
      for (int i = 0; i < 4; i++) begin
        if (wr_en && req.addr == tmr16_pkg::OFF_MATCH0 + 8'(4 * i))
          match_reg[i] <= req.wdata[15:0];
        if (cap_hit[i])
          capt_reg[i] <= timer_count_reg;
      end
    end
  end

  default clocking cb_chk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // match flag path: the tick that fires, then the clock that registers it
  sequence s_match0_irq;
    match_fire[0] && act_irq[0] ##1 1'b1;
  endsequence

  a_stop_on_match: assert property (
    do_stop && !wr_en |=>
      !run_ctrl_reg[tmr16_pkg::RUN_EN_POS] && $stable(timer_count_reg))
    else $error("timer still running after stop match");
  a_reset_on_match: assert property (
    do_reset && !run_ctrl_reg[1] && !wr_en |=> timer_count_reg == 16'h0000)
    else $error("count not cleared after reset match");
  a_irq_next_clk: assert property (
    s_match0_irq |=> irq_status_reg[0])
    else $error("match flag not raised one clock later");
  a_capture_load: assert property (
    cap_hit[1] |=> capt_reg[1] == $past(timer_count_reg))
    else $error("capture register missed the count");
  a_prescale_step: assert property (
    tick && !do_reset && !do_stop && !run_ctrl_reg[1] && !wr_en |=>
      timer_count_reg == $past(timer_count_reg) + 16'h0001 &&
      tick_cnt_reg == 16'h0000)
    else $error("count did not advance on prescale tick");
  a_hold_no_tick: assert property (
    !tick && !wr_en && !run_ctrl_reg[1] |=> $stable(timer_count_reg))
    else $error("count moved without a tick");
  a_pwm_cycle_low: assert property (
    pulse_width_control_reg[0] && cycle_start && match_reg[0] != 16'h0000 &&
      !match_fire[0] && !wr_en |=> !match_output[0])
    else $error("pwm output not low at cycle start");
  a_pwm_set_high: assert property (
    pulse_width_control_reg[0] && match_fire[0] && !wr_en |=> match_output[0])
    else $error("pwm output not high after its match");

endmodule : tmr16_top

/* File: tmr16_pins.sv */
// tmr16_pins: capture signal sources and match pin load for the timer.
// assumes one pclk domain; every change lands just after a rising edge.
`timescale 1ns/1ps

module tmr16_pins (
  input wire logic pclk,
  output logic [3:0] capture_input,
  input wire logic [3:0] match_output
);
  initial begin
    capture_input = 4'h0;
  end

  // each level is held 4 clocks so the 2-flop synchroniser cannot miss it
  task automatic pulse(input int ch);
    @(posedge pclk);
    capture_input[ch] <= 1'b1;
    repeat (4) @(posedge pclk);
    capture_input[ch] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse

  task automatic high_time(input int ch, input int n, output int hits);
    hits = 0;
    repeat (n) begin
      @(posedge pclk);
      if (match_output[ch] === 1'b1) begin
        hits++;
      end
    end
  endtask : high_time
endmodule : tmr16_pins

/* File: tmr16_top_tb_top.sv */
// tmr16_top_tb_top: apb driven self-checking bench for the 16-bit timer.
// assumes tmr16_pins models the capture sources and the match pin loads.
`timescale 1ns/1ps

module tmr16_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c0, c1;
  logic [3:0] capture_input, match_output;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int t0, hits, k;

  tmr16_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input(capture_input), .match_output(match_output), .irq(irq));
  tmr16_pins u_pins (.pclk(pclk), .capture_input(capture_input),
    .match_output(match_output));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task results;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // a hang counts as one mismatch and still ends in the report
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      $display("CHECK FAILED %0t timeout", $time);
      results();
    end
  end

  task chk_reg(input string what, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg

  task chk_bit(input string what, input logic got, exp);
    chk_reg(what, {31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg("read", rd, exp);
  endtask : rdc

  task wait_irq;
    k = 0;
    while (irq !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    if (irq !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t irq wait timed out", $time);
    end
  endtask : wait_irq

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) rdc(8'(i * 4), 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk_bit("slverr", rerr, 1'b1);
    chk_reg("unmapped", rd, 32'h0);
    // divider 2, match0 6 with irq and reset: 7 counts of 3 clocks
    wr(8'h0c, 32'h2);
    wr(8'h18, 32'h6);
    wr(8'h14, 32'h3);
    wr(8'h40, 32'h1);
    wr(8'h04, 32'h1);
    wait_irq();
    t0 = cyc;
    wr(8'h00, 32'h1);
    @(negedge pclk);
    chk_bit("irq clear", irq, 1'b0);
    wait_irq();
    chk_reg("period", 32'(cyc - t0), 32'd21);
    apb(1'b0, 8'h08, 32'h0);
    chk_bit("wrap", rd < 32'd7, 1'b1);
    wr(8'h40, 32'h0);
    repeat (25) @(posedge pclk);
    @(negedge pclk);
    chk_bit("masked", irq, 1'b0);
    rdc(8'h00, 32'h1);
    // match1 at 3 stops the timer
    wr(8'h04, 32'h2);
    wr(8'h14, 32'h20);
    wr(8'h1c, 32'h3);
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'h1);
    repeat (20) @(posedge pclk);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h3);
    // toggle, low, high and none on channels 0..3, all matching at 2
    wr(8'h04, 32'h2);
    wr(8'h14, 32'h0);
    for (int i = 0; i < 4; i++) wr(8'(8'h18 + i * 4), 32'h2);
    wr(8'h3c, 32'h27a);
    wr(8'h04, 32'h1);
    repeat (10) @(posedge pclk);
    @(negedge pclk);
    chk_reg("ext match", {28'h0, match_output}, 32'hd);
    // capture channel 1 on rising edge with irq
    wr(8'h00, 32'hff);
    wr(8'h28, 32'h28);
    wr(8'h40, 32'h20);
    apb(1'b0, 8'h08, 32'h0);
    c0 = rd;
    u_pins.pulse(1);
    apb(1'b0, 8'h08, 32'h0);
    c1 = rd;
    apb(1'b0, 8'h30, 32'h0);
    chk_bit("capture", rd > c0 && rd < c1, 1'b1);
    rdc(8'h00, 32'h20);
    chk_bit("capture irq", irq, 1'b1);
    // counter mode: rising edges of input 2
    wr(8'h04, 32'h2);
    wr(8'h28, 32'h0);
    wr(8'h70, 32'h9);
    wr(8'h04, 32'h1);
    repeat (5) u_pins.pulse(2);
    repeat (6) @(posedge pclk);
    rdc(8'h08, 32'h5);
    wr(8'h70, 32'h0);
    // pwm on output 0, cycle of 10 set by match3 reset
    wr(8'h04, 32'h2);
    wr(8'h3c, 32'h2);
    wr(8'h14, 32'h400);
    wr(8'h18, 32'h4);
    wr(8'h24, 32'h9);
    wr(8'h74, 32'h1);
    wr(8'h04, 32'h1);
    repeat (5) @(posedge pclk);
    u_pins.high_time(0, 20, hits);
    // match acts at the end of the count-4 tick: high for counts 5..9
    chk_reg("pwm high", 32'(hits), 32'd10);
    chk_bit("non pwm pin", match_output[1], 1'b1);
    results();
  end
endmodule : tmr16_top_tb_top
